// *** verilog/safety_io_monitor.sv ***
// dual-channel safety command decoder, limit monitors and test-pulsed status
`timescale 1ns/1ps
module safety_io_monitor (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_we,
   input wire logic i_re,
   output logic [31:0] o_rdata,
   // redundant command pins, channel a and b
   input wire logic [safety_io_pkg::NCMD-1:0] i_cmd_a,
   input wire logic [safety_io_pkg::NCMD-1:0] i_cmd_b,
   // motion feedback, same clock
   input wire logic [15:0] i_speed,
   input wire logic [15:0] i_torque,
   // safety actions and status
   output logic o_torque_off,
   output logic o_controlled_stop,
   output logic o_torque_off_status_output_a,
   output logic o_torque_off_status_output_b,
   output logic o_safe_speed_status_output,
   output logic o_direction_status,
   output logic o_irq
);
   import safety_io_pkg::*;

   localparam int TW = $clog2(US_CYC);

   typedef struct packed {
      logic [NCMD-1:0] s1a;
      logic [NCMD-1:0] s1b;
      logic [NCMD-1:0] s2a;
      logic [NCMD-1:0] s2b;
      logic [NCMD-1:0] cmd;
      logic [NCMD-1:0] cmd_p;
      logic [NCMD-1:0][15:0] mm_cnt;
      logic [TW-1:0] tick_cnt;
      logic [1:0] ctrl;
      logic [15:0] mism;
      logic [15:0] pw;
      logic [15:0] pp;
      logic [15:0] sdet;
      logic [15:0] safe_thr;
      logic [15:0] ovs_cnt;
      logic [15:0] pc;
      logic [NLIM-1:0][31:0] spd_lim;
      logic [NLIM-1:0][31:0] trq_lim;
      logic [NLIM-1:0][15:0] dcnt;
      logic [NEV-1:0] ev_st;
      logic [NEV-1:0] ev_msk;
      logic [31:0] rdata;
      logic irq;
      logic stop;
      logic toff;
      logic toff_a;
      logic toff_b;
      logic safe;
      logic dir;
   } state_s;

   state_s q;
   state_s d;
   logic tick;
   logic mm_over;
   logic ovs;
   logic trq;
   logic pulse_a;
   logic pulse_b;
   logic [15:0] spd_abs;
   logic [15:0] half;
   logic [15:0] wid;
   logic [15:0] det_lim;
   logic [NEV-1:0] ev;
   logic [NEV-1:0] clr;

   // next-state logic for the whole block
   always_comb begin
      d = q;
      // microsecond tick shared by every timer
      tick = (q.tick_cnt == TW'(US_CYC - 1));
      d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
      spd_abs = i_speed[15] ? 16'(-i_speed) : i_speed;

      // pins are asynchronous: two flops before any decode
      d.s1a = i_cmd_a;
      d.s1b = i_cmd_b;
      d.s2a = q.s1a;
      d.s2b = q.s1b;
      d.cmd = q.s2a & q.s2b;
      d.cmd_p = q.cmd;

      // per-pair mismatch timers
      mm_over = 1'b0;
      for (int i = 0; i < NCMD; i++) begin
         if (q.s2a[i] == q.s2b[i]) begin
            d.mm_cnt[i] = '0;
         end else if (tick && q.mm_cnt[i] != 16'hffff) begin
            d.mm_cnt[i] = q.mm_cnt[i] + 16'h0001;
         end
         if (q.mm_cnt[i] > q.mism) begin
            mm_over = 1'b1;
         end
      end

      // speed and torque limit sets
      ovs = 1'b0;
      trq = 1'b0;
      for (int i = 0; i < NLIM; i++) begin
         // deceleration window opens on the command's rising edge
         if (q.cmd[CMD_SPEED_LIM + i] && !q.cmd_p[CMD_SPEED_LIM + i]) begin
            d.dcnt[i] = q.spd_lim[i][31:16];
         end else if (tick && q.dcnt[i] != 16'h0000) begin
            d.dcnt[i] = q.dcnt[i] - 16'h0001;
         end
         if (q.cmd[CMD_SPEED_LIM + i] && q.cmd_p[CMD_SPEED_LIM + i] &&
             q.dcnt[i] == 16'h0000 && spd_abs > q.spd_lim[i][15:0]) begin
            ovs = 1'b1;
         end
         if (q.cmd[CMD_TORQUE_LIM + i] &&
             ($signed(i_torque) > $signed(q.trq_lim[i][31:16]) ||
              $signed(i_torque) < $signed(q.trq_lim[i][15:0]))) begin
            trq = 1'b1;
         end
      end

      // overspeed must persist; the fixed floor wins over a shorter setting
      if (!ovs) begin
         d.ovs_cnt = '0;
      end else if (tick && q.ovs_cnt != 16'hffff) begin
         d.ovs_cnt = q.ovs_cnt + 16'h0001;
      end
      det_lim = (q.sdet > SPD_FIX_US) ? q.sdet : SPD_FIX_US;

      // events
      ev[EV_MISMATCH] = mm_over;
      ev[EV_OVERSPEED] = ovs && q.ovs_cnt >= det_lim;
      ev[EV_DIRECTION] = (q.cmd[CMD_POS_DIR] && i_speed[15]) ||
         (q.cmd[CMD_NEG_DIR] && !i_speed[15] && i_speed != 16'h0000);
      ev[EV_TORQUE] = trq;

      // sticky status, write one to clear; a new event beats the clear
      clr = (i_we && i_addr == REG_EV_ST) ? i_wdata[NEV-1:0] : '0;
      d.ev_st = (q.ev_st & ~clr) | ev;
      d.irq = |(q.ev_st & q.ev_msk);

      // safety actions follow the latched faults, independent of the mask
      d.toff = q.cmd[CMD_TORQUE_OFF] | q.ev_st[EV_OVERSPEED];
      d.stop = q.cmd[CMD_CTRL_STOP] | q.ev_st[EV_MISMATCH] |
         q.ev_st[EV_DIRECTION] | q.ev_st[EV_TORQUE];
      d.dir = q.cmd[CMD_POS_DIR] | q.cmd[CMD_NEG_DIR];
      d.safe = q.ctrl[CTRL_SAFE_EN] && spd_abs <= q.safe_thr;

      // test pulses: a in the first half-period, b in the second
      half = {1'b0, q.pp[15:1]};
      wid = (q.pw >= half) ? half - 16'h0001 : q.pw;
      if (tick) begin
         d.pc = (q.pc >= q.pp - 16'h0001) ? 16'h0000 : q.pc + 16'h0001;
      end
      pulse_a = q.ctrl[CTRL_PULSE_EN] && half != 16'h0000 && q.pc < wid;
      pulse_b = q.ctrl[CTRL_PULSE_EN] && half != 16'h0000 &&
         q.pc >= half && q.pc < half + wid;
      d.toff_a = q.toff & ~pulse_a;
      d.toff_b = q.toff & ~pulse_b;

      // register writes
      if (i_we) begin
         case (i_addr)
            REG_CTRL: d.ctrl = i_wdata[1:0];
            REG_MISM: d.mism = i_wdata[15:0];
            REG_PW: d.pw = i_wdata[15:0];
            REG_PP: d.pp = i_wdata[15:0];
            REG_SDET: d.sdet = i_wdata[15:0];
            REG_SAFE_THR: d.safe_thr = i_wdata[15:0];
            REG_EV_MSK: d.ev_msk = i_wdata[NEV-1:0];
            default: ;
         endcase
         for (int i = 0; i < NLIM; i++) begin
            if (i_addr == REG_SPD_LIM0 + 8'(4 * i)) begin
               d.spd_lim[i] = i_wdata;
            end
            if (i_addr == REG_TRQ_LIM0 + 8'(4 * i)) begin
               d.trq_lim[i] = i_wdata;
            end
         end
      end

      // read data stands one cycle only; unmapped reads give zero
      d.rdata = '0;
      if (i_re) begin
         case (i_addr)
            REG_CTRL: d.rdata = 32'(q.ctrl);
            REG_MISM: d.rdata = 32'(q.mism);
            REG_PW: d.rdata = 32'(q.pw);
            REG_PP: d.rdata = 32'(q.pp);
            REG_SDET: d.rdata = 32'(q.sdet);
            REG_SAFE_THR: d.rdata = 32'(q.safe_thr);
            REG_CMD_ST: d.rdata = {4'h0, q.s2a ^ q.s2b, 4'h0, q.cmd};
            REG_EV_ST: d.rdata = 32'(q.ev_st);
            REG_EV_MSK: d.rdata = 32'(q.ev_msk);
            default: ;
         endcase
         for (int i = 0; i < NLIM; i++) begin
            if (i_addr == REG_SPD_LIM0 + 8'(4 * i)) begin
               d.rdata = q.spd_lim[i];
            end
            if (i_addr == REG_TRQ_LIM0 + 8'(4 * i)) begin
               d.rdata = q.trq_lim[i];
            end
         end
      end
   end

   // state register; clock enable freezes everything
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
         q.ctrl <= CTRL_RST;
         q.mism <= MISM_RST;
         q.pw <= PW_RST;
         q.pp <= PP_RST;
         q.sdet <= SDET_RST;
      end else if (i_ce) begin
         q <= d;
      end
   end

   // outputs straight from flops
   assign o_rdata = q.rdata;
   assign o_torque_off = q.toff;
   assign o_controlled_stop = q.stop;
   assign o_torque_off_status_output_a = q.toff_a;
   assign o_torque_off_status_output_b = q.toff_b;
   assign o_safe_speed_status_output = q.safe;
   assign o_direction_status = q.dir;
   assign o_irq = q.irq;

   // checks
   sequence s_toff_cmd;
      i_ce && q.cmd[CMD_TORQUE_OFF];
   endsequence
   sequence s_pins_differ;
      i_ce && q.s2a[CMD_SPEED_LIM] != q.s2b[CMD_SPEED_LIM];
   endsequence

   property p_cmd_mismatch;
      @(posedge i_clk) disable iff (i_rst) s_pins_differ |=> !q.cmd[CMD_SPEED_LIM];
   endproperty
   a_cmd_mismatch: assert property (p_cmd_mismatch) else $error("command on during mismatch");

   property p_cmd_on;
      @(posedge i_clk) disable iff (i_rst)
         $rose(q.cmd[CMD_SPEED_LIM]) |-> $past(q.s2a[CMD_SPEED_LIM] & q.s2b[CMD_SPEED_LIM]);
   endproperty
   a_cmd_on: assert property (p_cmd_on) else $error("command on without both pins");

   property p_alarm;
      @(posedge i_clk) disable iff (i_rst)
         $rose(q.ev_st[EV_MISMATCH]) |-> $past(mm_over) ##1 q.stop;
   endproperty
   a_alarm: assert property (p_alarm) else $error("mismatch alarm wrong");

   property p_mm_restart;
      @(posedge i_clk) disable iff (i_rst) (i_ce && q.s2a == q.s2b) |=> q.mm_cnt == '0;
   endproperty
   a_mm_restart: assert property (p_mm_restart) else $error("mismatch timer not cleared");

   property p_pulse_sep;
      @(posedge i_clk) disable iff (i_rst) (!q.toff_a && !q.toff_b) |-> !$past(q.toff);
   endproperty
   a_pulse_sep: assert property (p_pulse_sep) else $error("both status pins off together");

   property p_pulse_src;
      @(posedge i_clk) disable iff (i_rst)
         (!q.toff_a && $past(q.toff) && $past(i_ce)) |-> $past(pulse_a);
   endproperty
   a_pulse_src: assert property (p_pulse_src) else $error("status pin off without pulse");

   property p_ovs_fix;
      @(posedge i_clk) disable iff (i_rst)
         $rose(q.ev_st[EV_OVERSPEED]) |-> $past(q.ovs_cnt) >= SPD_FIX_US;
   endproperty
   a_ovs_fix: assert property (p_ovs_fix) else $error("overspeed under fixed time");

   property p_ovs_det;
      @(posedge i_clk) disable iff (i_rst)
         $rose(q.ev_st[EV_OVERSPEED]) |-> $past(q.ovs_cnt) >= $past(q.sdet) ##1 q.toff;
   endproperty
   a_ovs_det: assert property (p_ovs_det) else $error("overspeed before set time");

   property p_safe;
      @(posedge i_clk) disable iff (i_rst)
         q.safe |-> $past(q.ctrl[CTRL_SAFE_EN]) && $past(spd_abs) <= $past(q.safe_thr);
   endproperty
   a_safe: assert property (p_safe) else $error("safe-speed status wrong");

   property p_toff;
      @(posedge i_clk) disable iff (i_rst) s_toff_cmd |=> q.toff;
   endproperty
   a_toff: assert property (p_toff) else $error("torque off not applied");

endmodule // safety_io_monitor

// *** verilog/safety_io_pkg.sv ***
// constants for the dual-channel safety i/o monitor
package safety_io_pkg;
   // command channel map, one redundant pin pair each
   localparam int NCMD = 12;
   localparam int NLIM = 4;
   localparam int CMD_TORQUE_OFF = 0;
   localparam int CMD_CTRL_STOP = 1;
   localparam int CMD_SPEED_LIM = 2;
   localparam int CMD_POS_DIR = 6;
   localparam int CMD_NEG_DIR = 7;
   localparam int CMD_TORQUE_LIM = 8;
   // timing
   localparam int CLK_MHZ = 100;
   localparam int US_CYC = CLK_MHZ;
   localparam int SPD_FIX_TIME_MS = 1;
   localparam logic [15:0] SPD_FIX_US = 16'(SPD_FIX_TIME_MS * 1000);
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_MISM = 8'h04;
   localparam logic [7:0] REG_PW = 8'h08;
   localparam logic [7:0] REG_PP = 8'h0c;
   localparam logic [7:0] REG_SDET = 8'h10;
   localparam logic [7:0] REG_SAFE_THR = 8'h14;
   localparam logic [7:0] REG_CMD_ST = 8'h18;
   localparam logic [7:0] REG_EV_ST = 8'h1c;
   localparam logic [7:0] REG_EV_MSK = 8'h20;
   localparam logic [7:0] REG_SPD_LIM0 = 8'h24;
   localparam logic [7:0] REG_TRQ_LIM0 = 8'h34;
   // field positions
   localparam int CTRL_SAFE_EN = 0;
   localparam int CTRL_PULSE_EN = 1;
   localparam int NEV = 4;
   localparam int EV_MISMATCH = 0;
   localparam int EV_OVERSPEED = 1;
   localparam int EV_DIRECTION = 2;
   localparam int EV_TORQUE = 3;
   // reset values
   localparam logic [1:0] CTRL_RST = 2'h2;
   localparam logic [15:0] MISM_RST = 16'h2710;
   localparam logic [15:0] PW_RST = 16'h0001;
   localparam logic [15:0] PP_RST = 16'h03e8;
   localparam logic [15:0] SDET_RST = 16'h0000;
endpackage

// *** verification/safety_switch_model.sv ***
// safety switch model driving both channels of every command pair
`timescale 1ns/1ps
module safety_switch_model #(
   parameter int TP_PERIOD = 64,
   // contacts refresh every UPD_CYC clocks; a networked controller needs >= 12500
   parameter int UPD_CYC = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // requested commands, channel-b faults, diagnostic pulse enable
   input wire logic [safety_io_pkg::NCMD-1:0] i_req,
   input wire logic [safety_io_pkg::NCMD-1:0] i_split,
   input wire logic i_tp_en,
   // redundant pins
   output logic [safety_io_pkg::NCMD-1:0] o_pin_a,
   output logic [safety_io_pkg::NCMD-1:0] o_pin_b
);
   import safety_io_pkg::*;
   int tp_cnt;
   int upd_cnt;
   // contacts move just after the edge; a split bit leaves channel b open
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pin_a <= '0;
         o_pin_b <= '0;
         tp_cnt <= 0;
         upd_cnt <= 0;
      end else begin
         tp_cnt <= (tp_cnt == TP_PERIOD - 1) ? 0 : tp_cnt + 1;
         upd_cnt <= (upd_cnt >= UPD_CYC - 1) ? 0 : upd_cnt + 1;
         if (i_tp_en && tp_cnt == 0) begin
            o_pin_a <= '0;
            o_pin_b <= '0;
         end else if (upd_cnt == 0) begin
            o_pin_a <= i_req;
            o_pin_b <= i_req & ~i_split;
         end
      end
   end
endmodule // safety_switch_model

// *** verification/safety_io_dual_channel_monitor_tb_top.sv ***
// self-checking bench for the dual-channel safety i/o monitor
`timescale 1ns/1ps
module safety_io_dual_channel_monitor_tb_top;
   import safety_io_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] addr = '0;
   logic [31:0] wdata = '0;
   logic we = 1'b0;
   logic re = 1'b0;
   logic [15:0] speed = '0;
   logic [15:0] torque = '0;
   logic tp_en = 1'b0;
   logic [NCMD-1:0] req = '0;
   logic [NCMD-1:0] split = '0;
   logic [31:0] rdata;
   logic [NCMD-1:0] pin_a, pin_b;
   logic trq_off, c_stop, st_a, st_b, safe_spd, dir_st, irq;
   int bad_count = 0;
   int num_checks = 0;

   // 100 MHz clock
   always #5 i_clk = ~i_clk;

   safety_io_monitor uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_addr(addr),
      .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata), .i_cmd_a(pin_a),
      .i_cmd_b(pin_b), .i_speed(speed), .i_torque(torque), .o_torque_off(trq_off),
      .o_controlled_stop(c_stop), .o_torque_off_status_output_a(st_a),
      .o_torque_off_status_output_b(st_b), .o_safe_speed_status_output(safe_spd),
      .o_direction_status(dir_st), .o_irq(irq));

   safety_switch_model model (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_split(split),
      .i_tp_en(tp_en), .o_pin_a(pin_a), .o_pin_b(pin_b));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // settle one step past the edge so registered outputs have landed
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge i_clk);
      we <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_clk);
      addr <= a;
      re <= 1'b1;
      @(posedge i_clk);
      re <= 1'b0;
      #1;
      check(rdata, exp);
   endtask

   task automatic t_reset_values();
      rdchk(REG_CTRL, 32'(CTRL_RST));
      rdchk(REG_MISM, 32'(MISM_RST));
      rdchk(REG_PW, 32'(PW_RST));
      rdchk(REG_PP, 32'(PP_RST));
      // read data must fall back to zero one cycle later
      wait_cyc(1);
      check(rdata, 32'h0000_0000);
      rdchk(REG_SDET, 32'(SDET_RST));
      rdchk(8'hfc, 32'h0000_0000);
   endtask

   // one pair split, then matched, then split long enough to alarm
   task automatic t_pair();
      wr(REG_MISM, 32'h0000_0002);
      @(posedge i_clk);
      req <= 12'h004;
      split <= 12'h004;
      wait_cyc(8);
      rdchk(REG_CMD_ST, 32'h0004_0000);
      split <= 12'h000;
      wait_cyc(8);
      rdchk(REG_CMD_ST, 32'h0000_0004);
      split <= 12'h004;
      wait_cyc(150);
      split <= 12'h000;
      wait_cyc(10);
      split <= 12'h004;
      wait_cyc(150);
      split <= 12'h000;
      rdchk(REG_EV_ST, 32'h0000_0000);
      split <= 12'h004;
      wait_cyc(400);
      rdchk(REG_EV_ST, 32'h0000_0001);
      check(32'(c_stop), 32'h0000_0001);
      split <= 12'h000;
      wr(REG_EV_MSK, 32'h0000_0001);
      wait_cyc(3);
      check(32'(irq), 32'h0000_0001);
      wr(REG_EV_MSK, 32'h0000_0000);
      wait_cyc(3);
      check(32'(irq), 32'h0000_0000);
      wr(REG_EV_MSK, 32'h0000_0001);
      wr(REG_EV_ST, 32'h0000_0001);
      wait_cyc(3);
      check(32'(irq), 32'h0000_0000);
      check(32'(c_stop), 32'h0000_0000);
      req <= 12'h000;
   endtask

   task automatic t_stop_commands();
      @(posedge i_clk);
      req <= 12'h003;
      wait_cyc(6);
      check(32'(trq_off), 32'h0000_0001);
      check(32'(c_stop), 32'h0000_0001);
      req <= 12'h000;
      wait_cyc(6);
      check(32'(trq_off), 32'h0000_0000);
   endtask

   // two whole pulse periods: exact low time per pin, never both low
   task automatic t_pulses();
      int na;
      int nb;
      int nab;
      na = 0;
      nb = 0;
      nab = 0;
      wr(REG_PP, 32'h0000_000a);
      wr(REG_PW, 32'h0000_0002);
      req <= 12'h001;
      wait_cyc(20);
      repeat (2000) begin
         wait_cyc(1);
         na += (st_a === 1'b0);
         nb += (st_b === 1'b0);
         nab += (st_a === 1'b0 && st_b === 1'b0);
      end
      check(32'(na), 32'd400);
      check(32'(nb), 32'd400);
      check(32'(nab), 32'd0);
      req <= 12'h000;
   endtask

   // diagnostic pulses hit both channels together, so no mismatch alarm
   task automatic t_diag();
      @(posedge i_clk);
      tp_en <= 1'b1;
      req <= 12'h004;
      wait_cyc(400);
      rdchk(REG_EV_ST, 32'h0000_0000);
      @(posedge i_clk);
      tp_en <= 1'b0;
      req <= 12'h000;
   endtask

   // deceleration window, then overspeed far shorter than the fixed floor
   task automatic t_overspeed();
      wr(REG_SPD_LIM0, 32'h0003_0010);
      speed <= 16'h0020;
      req <= 12'h004;
      wait_cyc(10);
      check(32'(uut.ovs), 32'h0000_0000);
      wait_cyc(600);
      check(32'(uut.ovs), 32'h0000_0001);
      check(32'(trq_off), 32'h0000_0000);
      @(posedge i_clk);
      speed <= 16'h0000;
      req <= 12'h000;
      rdchk(REG_EV_ST, 32'h0000_0000);
   endtask

   task automatic t_speed_dir();
      wr(REG_CTRL, 32'h0000_0003);
      wr(REG_SAFE_THR, 32'h0000_0064);
      speed <= 16'h0064;
      wait_cyc(4);
      check(32'(safe_spd), 32'h0000_0001);
      @(posedge i_clk);
      speed <= 16'h0065;
      wait_cyc(4);
      check(32'(safe_spd), 32'h0000_0000);
      wr(REG_CTRL, 32'h0000_0002);
      speed <= 16'h0000;
      req <= 12'h040;
      wait_cyc(6);
      check(32'(safe_spd), 32'h0000_0000);
      check(32'(dir_st), 32'h0000_0001);
      rdchk(REG_EV_ST, 32'h0000_0000);
      @(posedge i_clk);
      speed <= 16'hfff0;
      wait_cyc(3);
      rdchk(REG_EV_ST, 32'h0000_0004);
      check(32'(c_stop), 32'h0000_0001);
      @(posedge i_clk);
      speed <= 16'h0000;
      wr(REG_EV_ST, 32'h0000_0004);
      req <= 12'h080;
      wait_cyc(6);
      check(32'(dir_st), 32'h0000_0001);
      rdchk(REG_EV_ST, 32'h0000_0000);
      @(posedge i_clk);
      speed <= 16'h0010;
      wait_cyc(3);
      rdchk(REG_EV_ST, 32'h0000_0004);
      check(32'(c_stop), 32'h0000_0001);
      @(posedge i_clk);
      speed <= 16'h0000;
      req <= 12'h000;
      wr(REG_EV_ST, 32'h0000_0004);
      wait_cyc(6);
      check(32'(dir_st), 32'h0000_0000);
      check(32'(c_stop), 32'h0000_0000);
   endtask

   // torque set one: inside the band, below it, then above it during a clear
   task automatic t_torque();
      wr(REG_TRQ_LIM0, 32'h0064_ff9c);
      torque <= 16'h0064;
      req <= 12'h100;
      wait_cyc(8);
      rdchk(REG_EV_ST, 32'h0000_0000);
      @(posedge i_clk);
      torque <= 16'hff9b;
      wait_cyc(3);
      rdchk(REG_EV_ST, 32'h0000_0008);
      @(posedge i_clk);
      torque <= 16'h0065;
      wr(REG_EV_ST, 32'h0000_0008);
      wait_cyc(3);
      rdchk(REG_EV_ST, 32'h0000_0008);
      @(posedge i_clk);
      torque <= 16'h0000;
      req <= 12'h000;
      wr(REG_EV_ST, 32'h0000_0008);
      wait_cyc(6);
      rdchk(REG_EV_ST, 32'h0000_0000);
      check(32'(c_stop), 32'h0000_0000);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // the sequence needs some 4000 cycles; over twelve times that means a hang
   initial begin
      #500_000;
      bad_count++;
      complete_run();
   end

   initial begin
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      t_reset_values();
      t_pair();
      t_stop_commands();
      t_pulses();
      t_diag();
      t_overspeed();
      t_speed_dir();
      t_torque();
      complete_run();
   end
endmodule // safety_io_dual_channel_monitor_tb_top
